// ---- hw/system_clock_generator.sv ----
`timescale 1ns/1ps
`default_nettype none
module system_clock_generator
    import clkgen_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       ctrl0_we,
    input  wire logic [7:0] ctrl0_wdata,
    input  wire logic       ctrl1_we,
    input  wire logic [7:0] ctrl1_wdata,
    input  wire logic       div_we,
    input  wire logic [7:0] div_wdata,
    input  wire logic       bus_clock_out_sel,
    input  wire logic       ext_bus_mode,
    input  wire logic       wait_exec,
    input  wire logic       stop_wake,
    input  wire logic       sub_osc_in,
    output logic [7:0]      ctrl0_q,
    output logic [7:0]      ctrl1_q,
    output logic [7:0]      div_q,
    output logic            main_osc_run,
    output logic            main_osc_drive,
    output logic            sub_osc_run,
    output logic            sub_osc_drive,
    output logic            watchdog_action_sel,
    output logic            bus_clk_en,
    output logic            bus_clk_src_sub,
    output logic            periph_clk_div1,
    output logic            periph_clk_div8,
    output logic            periph_clk_div32,
    output logic            serial2_clk_div1,
    output logic            serial2_clk_div8,
    output logic            serial2_clk_div32,
    output logic            ad_clk_en,
    output logic            sub_freq_clock,
    output logic            sub_div32_clock,
    output logic            wdt_clk_en,
    output logic            clk_out_pin,
    output logic            clk_out_oe
);

    // legal main ratios; anything else written to the divider is dropped
    function automatic logic legal_ratio(input logic [7:0] r);
        case (r)
            8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08,
            8'h0A, 8'h0C, 8'h0E, 8'h10: legal_ratio = 1'b1;
            default: legal_ratio = 1'b0;
        endcase
    endfunction

    // ==========================================================
    // control registers
    logic [7:0] c0_d, c1_d, div_d;
    logic       stop_entry;

    always_comb begin
        c0_d       = ctrl0_q;
        c1_d       = ctrl1_q;
        div_d      = div_q;
        stop_entry = ctrl1_we && ctrl1_wdata[C1_ALL_STP] && !ctrl1_q[C1_ALL_STP];
        if (stop_wake) begin
            c1_d[C1_ALL_STP] = 1'b0;
        end
        if (ctrl0_we) begin
            c0_d = ctrl0_wdata;
            c0_d[C0_WDT_ACT] = ctrl0_wdata[C0_WDT_ACT] | ctrl0_q[C0_WDT_ACT];
        end
        if (ctrl1_we) begin
            c1_d = ctrl1_wdata & C1_MASK;
        end
        if (stop_entry) begin
            c0_d[C0_SUB_DRV] = 1'b1;
            if (!ctrl0_q[C0_SRC]) begin
                c1_d[C1_MAIN_DRV] = 1'b1;
            end else begin
                c1_d[C1_MAIN_DRV] = ctrl1_q[C1_MAIN_DRV];
            end
        end
        if (div_we && legal_ratio(div_wdata)) begin
            div_d = div_wdata;
        end
        if (c0_d[C0_MAIN_STP] || c1_d[C1_ALL_STP]) begin
            div_d = DIV_RESET;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl0_q <= C0_RESET;
            ctrl1_q <= C1_RESET;
            div_q   <= DIV_RESET;
        end else begin
            ctrl0_q <= c0_d;
            ctrl1_q <= c1_d;
            div_q   <= div_d;
        end
    end

    logic clocks_on;
    logic main_run;
    logic sub_run;
    assign clocks_on = !ctrl1_q[C1_ALL_STP];
    assign main_run  = clocks_on && !ctrl0_q[C0_MAIN_STP];
    assign sub_run   = clocks_on && ctrl0_q[C0_SUB_EN];

    assign main_osc_run        = main_run;
    assign main_osc_drive      = ctrl1_q[C1_MAIN_DRV];
    assign sub_osc_run         = sub_run;
    assign sub_osc_drive       = ctrl0_q[C0_SUB_DRV];
    assign watchdog_action_sel = ctrl0_q[C0_WDT_ACT];

    // ==========================================================
    // sub oscillator pin synchroniser
    // the level only moves once stages two and three agree
    logic s1_q, s2_q, s3_q, sub_lvl_q, sub_lvl_d;

    always_comb begin
        sub_lvl_d = sub_lvl_q;
        if (s2_q == s3_q) begin
            sub_lvl_d = s3_q;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s1_q      <= 1'b0;
            s2_q      <= 1'b0;
            s3_q      <= 1'b0;
            sub_lvl_q <= 1'b0;
        end else begin
            s1_q      <= sub_osc_in;
            s2_q      <= s1_q;
            s3_q      <= s2_q;
            sub_lvl_q <= sub_lvl_d;
        end
    end

    logic sub_rise;
    assign sub_rise       = sub_run && sub_lvl_d && !sub_lvl_q;
    assign sub_freq_clock = sub_rise;
    assign wdt_clk_en     = sub_rise;

    // ==========================================================
    // bus clock divider and source switch
    logic [7:0] ratio_q, ratio_d;
    logic [3:0] cnt_q, cnt_d;
    logic       src_q, src_d;
    logic       bclk_lvl_q, bclk_lvl_d;
    logic       main_wrap, main_lvl;

    assign main_wrap = main_run && ({4'h0, cnt_q} == ratio_q - 8'h01);
    // ratio one has no high phase, so it pulses every cycle
    assign main_lvl  = ({4'h0, cnt_q} < {1'b0, ratio_q[7:1]});

    always_comb begin
        ratio_d    = ratio_q;
        cnt_d      = cnt_q;
        src_d      = src_q;
        bclk_lvl_d = src_q ? sub_lvl_q : main_lvl;
        if (main_run) begin
            if (main_wrap) begin
                cnt_d   = 4'h0;
                ratio_d = div_q;
            end else begin
                cnt_d = cnt_q + 4'h1;
            end
        end
        // a switch waits until the running and the new clock are both low
        if (ctrl0_q[C0_SRC] != src_q && !bclk_lvl_q &&
            !(ctrl0_q[C0_SRC] ? sub_lvl_q : main_lvl)) begin
            src_d = ctrl0_q[C0_SRC];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ratio_q    <= DIV_RESET;
            cnt_q      <= 4'h0;
            src_q      <= 1'b0;
            bclk_lvl_q <= 1'b0;
        end else begin
            ratio_q    <= ratio_d;
            cnt_q      <= cnt_d;
            src_q      <= src_d;
            bclk_lvl_q <= bclk_lvl_d;
        end
    end

    assign bus_clk_en      = clocks_on && (src_q ? sub_rise : main_wrap);
    assign bus_clk_src_sub = src_q;

    // ==========================================================
    // peripheral prescaler and timer count divider
    logic [4:0] pre_q, pre_d, sub32_q, sub32_d;
    logic       periph_on;

    assign periph_on = main_run && !(ctrl0_q[C0_WAIT_PS] && wait_exec);

    always_comb begin
        pre_d   = pre_q;
        sub32_d = sub32_q;
        if (main_run) begin
            pre_d = pre_q + 5'h01;
        end
        if (sub_rise) begin
            sub32_d = sub32_q + 5'h01;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pre_q   <= 5'h00;
            sub32_q <= 5'h00;
        end else begin
            pre_q   <= pre_d;
            sub32_q <= sub32_d;
        end
    end

    assign periph_clk_div1   = periph_on;
    assign periph_clk_div8   = periph_on && ((pre_q & PRE_F8_MASK) == PRE_F8_MASK);
    assign periph_clk_div32  = periph_on && (pre_q == PRE_F32_TC);
    assign serial2_clk_div1  = periph_clk_div1;
    assign serial2_clk_div8  = periph_clk_div8;
    assign serial2_clk_div32 = periph_clk_div32;
    assign ad_clk_en         = main_run;
    assign sub_div32_clock   = sub_rise && (sub32_q == SUB32_TC);

    // ==========================================================
    // clock output pin
    logic [1:0] out_sel;
    logic       pin_d, oe_d, pin_q, oe_q;

    assign out_sel = {ctrl0_q[C0_OUT_HI], ctrl0_q[C0_OUT_LO]};

    always_comb begin
        pin_d = 1'b0;
        oe_d  = 1'b1;
        case (out_sel)
            OUT_SUB: pin_d = sub_lvl_q && sub_run;
            OUT_F8:  pin_d = periph_on && pre_q[2];
            OUT_F32: pin_d = periph_on && pre_q[4];
            OUT_PORT: begin
                // bus clock only leaves the chip in the external bus modes
                if (ext_bus_mode && !bus_clock_out_sel) begin
                    pin_d = bclk_lvl_q;
                end else begin
                    oe_d = 1'b0;
                end
            end
            default: oe_d = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pin_q <= 1'b0;
            oe_q  <= 1'b0;
        end else begin
            pin_q <= pin_d;
            oe_q  <= oe_d;
        end
    end

    assign clk_out_pin = pin_q;
    assign clk_out_oe  = oe_q;

    // ==========================================================
    // checks
    sequence s_main_pulse8;
        main_wrap && !src_q && ratio_q == DIV_RESET && div_q == DIV_RESET;
    endsequence
    sequence s_quiet7;
        (!main_wrap && main_run && div_q == DIV_RESET)[*7];
    endsequence

    a_div_forced: assert property (@(posedge core_clk) disable iff (!nrst)
        (ctrl0_q[C0_MAIN_STP] || ctrl1_q[C1_ALL_STP]) |-> div_q == DIV_RESET)
        else $error("divider not forced to eight");
    a_wdt_sticky: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(ctrl0_q[C0_WDT_ACT]) |-> ctrl0_q[C0_WDT_ACT])
        else $error("watchdog action bit cleared");
    a_stop_subdrv: assert property (@(posedge core_clk) disable iff (!nrst)
        stop_entry |=> sub_osc_drive && !clocks_on)
        else $error("sub drive not forced on stop");
    a_stop_maindrv: assert property (@(posedge core_clk) disable iff (!nrst)
        stop_entry && !ctrl0_q[C0_SRC] |=> main_osc_drive)
        else $error("main drive not forced on stop");
    a_low_keep: assert property (@(posedge core_clk) disable iff (!nrst)
        stop_entry && ctrl0_q[C0_SRC] && !ctrl1_q[C1_MAIN_DRV] |=> !main_osc_drive)
        else $error("main drive forced in low speed");
    a_wait_periph: assert property (@(posedge core_clk) disable iff (!nrst)
        wait_exec && ctrl0_q[C0_WAIT_PS] |-> !periph_clk_div1 && !periph_clk_div8)
        else $error("peripheral clock in wait");
    a_sub_off: assert property (@(posedge core_clk) disable iff (!nrst)
        !ctrl0_q[C0_SUB_EN] |-> !sub_freq_clock && !sub_div32_clock)
        else $error("sub tick while sub off");
    a_switch_low: assert property (@(posedge core_clk) disable iff (!nrst)
        src_q != $past(src_q) |-> !$past(bclk_lvl_q))
        else $error("source switched on high level");
    a_div8_spacing: assert property (@(posedge core_clk) disable iff (!nrst)
        s_main_pulse8 ##1 s_quiet7 ##1 main_run |-> main_wrap)
        else $error("divide by eight spacing wrong");
    a_stop_clocks: assert property (@(posedge core_clk) disable iff (!nrst)
        ctrl1_q[C1_ALL_STP] |-> !bus_clk_en && !ad_clk_en && !wdt_clk_en)
        else $error("clock running in stop mode");

endmodule
`default_nettype wire

// ---- hw/clkgen_pkg.sv ----
package clkgen_pkg;
    // clock control register 0 fields
    localparam int C0_OUT_LO   = 0;
    localparam int C0_OUT_HI   = 1;
    localparam int C0_WAIT_PS  = 2;
    localparam int C0_SUB_DRV  = 3;
    localparam int C0_SUB_EN   = 4;
    localparam int C0_MAIN_STP = 5;
    localparam int C0_WDT_ACT  = 6;
    localparam int C0_SRC      = 7;
    // clock control register 1 fields
    localparam int C1_ALL_STP  = 0;
    localparam int C1_MAIN_DRV = 5;
    localparam logic [7:0] C1_MASK  = 8'h21;
    // reset values
    localparam logic [7:0] C0_RESET  = 8'h08;
    localparam logic [7:0] C1_RESET  = 8'h20;
    localparam logic [7:0] DIV_RESET = 8'h08;
    // clock output select encodings
    localparam logic [1:0] OUT_PORT = 2'h0;
    localparam logic [1:0] OUT_SUB  = 2'h1;
    localparam logic [1:0] OUT_F8   = 2'h2;
    localparam logic [1:0] OUT_F32  = 2'h3;
    // prescaler terminal counts
    localparam logic [4:0] PRE_F8_MASK = 5'h07;
    localparam logic [4:0] PRE_F32_TC  = 5'h1F;
    localparam logic [4:0] SUB32_TC    = 5'h1F;
endpackage

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb
    import clkgen_pkg::*;
;
    // ==========================================
    // clock, reset and design hookup
    logic       core_clk = 1'b0;
    logic       nrst = 1'b0;
    logic       ctrl0_we = 1'b0, ctrl1_we = 1'b0, div_we = 1'b0;
    logic [7:0] ctrl0_wdata = 8'h00, ctrl1_wdata = 8'h00, div_wdata = 8'h00;
    logic       bus_clock_out_sel = 1'b0, ext_bus_mode = 1'b0, wait_exec = 1'b0;
    logic       stop_wake = 1'b0, sub_osc_in = 1'b0;
    logic [7:0] ctrl0_q, ctrl1_q, div_q;
    logic       main_osc_run, main_osc_drive, sub_osc_run, sub_osc_drive;
    logic       watchdog_action_sel, bus_clk_en, bus_clk_src_sub;
    logic       periph_clk_div1, periph_clk_div8, periph_clk_div32;
    logic       serial2_clk_div1, serial2_clk_div8, serial2_clk_div32;
    logic       ad_clk_en, sub_freq_clock, sub_div32_clock, wdt_clk_en;
    logic       clk_out_pin, clk_out_oe;
    int         failures = 0;
    int         n_tests = 0;
    int         sub_div = 0;
    int         p;
    int         i;

    always #4 core_clk = ~core_clk;

    // sub pin swings slowly and runs free; the block must ignore it until enabled
    always @(negedge core_clk) begin
        sub_div <= (sub_div == 5) ? 0 : sub_div + 1;
        if (sub_div == 5)
            sub_osc_in <= ~sub_osc_in;
    end

    system_clock_generator u_dut (
        .core_clk(core_clk), .nrst(nrst), .ctrl0_we(ctrl0_we), .ctrl0_wdata(ctrl0_wdata),
        .ctrl1_we(ctrl1_we), .ctrl1_wdata(ctrl1_wdata), .div_we(div_we), .div_wdata(div_wdata),
        .bus_clock_out_sel(bus_clock_out_sel), .ext_bus_mode(ext_bus_mode),
        .wait_exec(wait_exec), .stop_wake(stop_wake), .sub_osc_in(sub_osc_in),
        .ctrl0_q(ctrl0_q), .ctrl1_q(ctrl1_q), .div_q(div_q), .main_osc_run(main_osc_run),
        .main_osc_drive(main_osc_drive), .sub_osc_run(sub_osc_run),
        .sub_osc_drive(sub_osc_drive), .watchdog_action_sel(watchdog_action_sel),
        .bus_clk_en(bus_clk_en), .bus_clk_src_sub(bus_clk_src_sub),
        .periph_clk_div1(periph_clk_div1), .periph_clk_div8(periph_clk_div8),
        .periph_clk_div32(periph_clk_div32), .serial2_clk_div1(serial2_clk_div1),
        .serial2_clk_div8(serial2_clk_div8), .serial2_clk_div32(serial2_clk_div32),
        .ad_clk_en(ad_clk_en), .sub_freq_clock(sub_freq_clock),
        .sub_div32_clock(sub_div32_clock), .wdt_clk_en(wdt_clk_en),
        .clk_out_pin(clk_out_pin), .clk_out_oe(clk_out_oe)
    );

    // ==========================================
    // tasks
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic hang(input string msg);
        failures++;
        $display("Error at %0t: no answer while waiting for %s", $time, msg);
        wrap_up();
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // r: 0 ctrl0, 1 ctrl1, 2 divider; strobe is dropped one edge later
    task automatic wr(input int r, input logic [7:0] d);
        @(negedge core_clk);
        ctrl0_we = (r == 0);
        ctrl1_we = (r == 1);
        div_we = (r == 2);
        ctrl0_wdata = d;
        ctrl1_wdata = d;
        div_wdata = d;
        @(negedge core_clk);
        ctrl0_we = 1'b0;
        ctrl1_we = 1'b0;
        div_we = 1'b0;
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return bus_clk_en;
            1: return periph_clk_div8;
            2: return periph_clk_div32;
            3: return serial2_clk_div8;
            4: return serial2_clk_div32;
            5: return sub_freq_clock;
            6: return sub_div32_clock;
            default: return wdt_clk_en;
        endcase
    endfunction

    // cycles from one pulse of the chosen output to the next
    task automatic period(input int s, output int n);
        int k;
        for (k = 0; k < 1000 && pick(s) !== 1'b1; k++)
            @(negedge core_clk);
        if (k >= 1000)
            hang("first pulse");
        @(negedge core_clk);
        n = 1;
        while (pick(s) !== 1'b1 && n < 1000) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 1000)
            hang("second pulse");
    endtask

    task automatic src_wait(input logic want);
        int k;
        for (k = 0; k < 1000 && bus_clk_src_sub !== want; k++)
            @(negedge core_clk);
        if (k >= 1000)
            hang("source switch");
    endtask

    task automatic done_test(input string name);
        $display("test %s finished", name);
    endtask

    // ==========================================
    // main sequence
    initial begin : main_seq
        int ratios [10];
        ratios = '{1, 2, 3, 4, 6, 8, 10, 12, 14, 16};
        tick(3);
        nrst = 1'b1;
        chk(16'(ctrl0_q), 16'h0008, "ctrl0 reset");
        chk(16'(ctrl1_q), 16'h0020, "ctrl1 reset");
        chk(16'(div_q), 16'h0008, "div reset");
        chk(16'(clk_out_oe), 16'h0000, "pin idle");
        period(0, p); chk(16'(p), 16'h0008, "bus period reset");
        for (i = 1; i < 5; i++) begin
            period(i, p); chk(16'(p), (i % 2) ? 16'h0008 : 16'h0020, "periph period");
        end
        chk(16'(serial2_clk_div1), 16'h0001, "serial div1");
        tick(200);
        chk(16'(sub_osc_run), 16'h0000, "sub off");
        chk(16'(pick(5) | pick(7)), 16'h0000, "no sub pulse");
        done_test("reset");
        for (i = 0; i < 10; i++) begin
            wr(2, 8'(ratios[i])); chk(16'(div_q), 16'(ratios[i]), "div readback");
            period(0, p); period(0, p);
            chk(16'(p), 16'(ratios[i]), "bus ratio");
        end
        wr(2, 8'h05); chk(16'(div_q), 16'h0010, "illegal ratio");
        done_test("divider");
        wr(0, 8'h38);
        chk(16'(main_osc_run), 16'h0000, "main stop");
        chk(16'(div_q), 16'h0008, "div forced");
        tick(2); chk(16'(periph_clk_div1), 16'h0000, "periph halted");
        wr(0, 8'h18); wr(2, 8'h02);
        chk(16'(main_osc_run), 16'h0001, "main run");
        chk(16'(sub_osc_run), 16'h0001, "sub run");
        period(5, p); chk(16'(p), 16'h000C, "sub rate");
        period(7, p); chk(16'(p), 16'h000C, "watchdog rate");
        period(6, p); chk(16'(p), 16'h0180, "sub div32");
        done_test("oscillators");
        wr(0, 8'h1C); wait_exec = 1'b1; tick(3);
        chk(16'(periph_clk_div1), 16'h0000, "wait stop");
        chk(16'(ad_clk_en), 16'h0001, "converter clock");
        wait_exec = 1'b0; tick(3);
        chk(16'(periph_clk_div1), 16'h0001, "wait resume");
        done_test("wait");
        wr(1, 8'h00); wr(0, 8'h90); src_wait(1'b1);
        wr(1, 8'h01);
        chk(16'(main_osc_drive), 16'h0000, "drive kept");
        chk(16'(sub_osc_drive), 16'h0001, "sub drive stop");
        @(negedge core_clk); stop_wake = 1'b1; @(negedge core_clk); stop_wake = 1'b0;
        chk(16'(ctrl1_q[C1_ALL_STP]), 16'h0000, "wake");
        wr(0, 8'h18); src_wait(1'b0);
        wr(2, 8'h02); wr(1, 8'h00); wr(1, 8'h01);
        chk(16'(main_osc_drive), 16'h0001, "drive forced");
        chk(16'(div_q), 16'h0008, "div stop");
        tick(2);
        chk(16'({periph_clk_div1, ad_clk_en, bus_clk_en}), 16'h0000, "all off");
        @(negedge core_clk); stop_wake = 1'b1; @(negedge core_clk); stop_wake = 1'b0;
        done_test("stop");
        wr(0, 8'h58); wr(0, 8'h18);
        chk(16'(watchdog_action_sel), 16'h0001, "watchdog sticky");
        ext_bus_mode = 1'b1;
        for (i = 0; i < 4; i++) begin
            wr(0, 8'h58 | 8'(i)); tick(2);
            chk(16'(clk_out_oe), 16'h0001, "pin drive");
        end
        wr(0, 8'h58); tick(2); chk(16'(clk_out_oe), 16'h0001, "bus clock out");
        bus_clock_out_sel = 1'b1;
        tick(3);
        chk(16'(clk_out_oe), 16'h0000, "bus clock held back");
        bus_clock_out_sel = 1'b0;
        ext_bus_mode = 1'b0; tick(3);
        chk(16'(clk_out_oe), 16'h0000, "single chip port");
        // divide-by-8 square on the pin: half of any 32 cycles are high
        wr(0, 8'h5A);
        tick(2);
        p = 0;
        for (i = 0; i < 32; i++) begin
            @(negedge core_clk);
            p += int'(clk_out_pin);
        end
        chk(16'(p), 16'h0010, "div8 pin duty");
        done_test("clock out");
        wrap_up();
    end
endmodule
`default_nettype wire
